// [design/rfct_defs.svh]
// register offsets, field positions, reset values and timing counts of the countdown timer
`ifndef RFCT_DEFS_SVH
`define RFCT_DEFS_SVH

`define RFCT_ADDR_W          8
`define RFCT_IDX_TICK_CFG    6'h2A
`define RFCT_IDX_TRIG_CFG    6'h2B
`define RFCT_IDX_PRESET      6'h2C
`define RFCT_IDX_CONTROL     6'h30
`define RFCT_IDX_STATUS      6'h31

`define RFCT_RST_TICK_CFG    8'h0B
`define RFCT_RST_TRIG_CFG    8'h02
`define RFCT_RST_PRESET      8'h00

`define RFCT_TICK_AUTO_BIT   5
`define RFCT_TICK_EXP_MSB    4
`define RFCT_TICK_WR_MASK    8'h3F
`define RFCT_TRIG_HALT_RXF   3
`define RFCT_TRIG_HALT_RX1   2
`define RFCT_TRIG_LNCH_TXF   1
`define RFCT_TRIG_LNCH_TX1   0
`define RFCT_TRIG_WR_MASK    8'h0F
`define RFCT_CTRL_START_BIT  0
`define RFCT_CTRL_STOP_BIT   1
`define RFCT_STAT_EXP_BIT    0
`define RFCT_STAT_RUN_BIT    1
`define RFCT_STAT_CNT_LSB    8

`define RFCT_CLK_KHZ         100000
`define RFCT_REF_KHZ         13560
`define RFCT_EXP_MAX         5'h15
`define RFCT_DIV_W           22

`define RFCT_RESP_OKAY       2'h0
`define RFCT_RESP_SLVERR     2'h2

`endif

// [design/rfct_pkg.sv]
// types shared by the countdown timer modules
`include "rfct_defs.svh"

package rfct_pkg;

  typedef struct packed {
    logic [`RFCT_ADDR_W-1:0] awaddr;
    logic                    awvalid;
    logic [31:0]             wdata;
    logic [3:0]              wstrb;
    logic                    wvalid;
    logic                    bready;
    logic [`RFCT_ADDR_W-1:0] araddr;
    logic                    arvalid;
    logic                    rready;
  } rfct_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rfct_axi_rsp_t;

  typedef struct packed {
    logic tx_first_bit;
    logic tx_finish;
    logic rx_first_bit;
    logic rx_finish;
  } rfct_events_t;

  typedef enum logic {RFCT_IDLE, RFCT_COUNTING} rfct_run_t;

  typedef struct packed {
    logic                    aw_full;
    logic [`RFCT_ADDR_W-1:0] aw_addr;
    logic                    w_full;
    logic [31:0]             w_data;
    logic [3:0]              w_strb;
    rfct_axi_rsp_t           rsp;
    logic [7:0]              timer_tick_config;
    logic [7:0]              timer_trigger_config;
    logic [7:0]              countdown_preset;
    logic                    sw_start;
    logic                    sw_stop;
    rfct_run_t               run;
    logic [7:0]              count;
    logic                    countdown_expired_flag;
  } rfct_state_t;

  typedef struct packed {
    logic start;
    logic stop;
  } rfct_trig_state_t;

  typedef struct packed {
    logic [13:0]            acc;
    logic [`RFCT_DIV_W-1:0] div_cnt;
    logic                   tick;
  } rfct_pre_state_t;

endpackage : rfct_pkg

// [design/rfct_prescaler.sv]
// tick generator: 13.56 MHz reference from the system clock, then divide by 2 to the exponent
`timescale 1ns/1ps
`include "rfct_defs.svh"

module rfct_prescaler
  import rfct_pkg::*;
#(
  parameter int CLK_KHZ = `RFCT_CLK_KHZ,
  parameter int REF_KHZ = `RFCT_REF_KHZ
) (
  input  logic       clk,
  input  logic       rst,
  input  logic       clear,
  input  logic [4:0] exponent,
  output logic       tick
);

  localparam logic [13:0] STEP = 14'(REF_KHZ / 10);
  localparam logic [13:0] MODV = 14'(CLK_KHZ / 10);

  rfct_pre_state_t st;
  rfct_pre_state_t next_st;

  always_comb begin
    logic                   ref_en;
    logic [14:0]            sum;
    logic [4:0]             exp_c;
    logic [`RFCT_DIV_W-1:0] mask;
    next_st = st;
    sum     = {1'b0, st.acc} + {1'b0, STEP};
    ref_en  = (sum >= {1'b0, MODV});
    exp_c   = (exponent > `RFCT_EXP_MAX) ? `RFCT_EXP_MAX : exponent;
    mask    = (`RFCT_DIV_W'(1) << exp_c) - `RFCT_DIV_W'(1);
    // fractional accumulator gives the reference rate on average
    next_st.acc  = ref_en ? 14'(sum - {1'b0, MODV}) : sum[13:0];
    next_st.tick = 1'b0;
    if (clear) begin
      next_st.div_cnt = '0;
    end else if (ref_en) begin
      // one tick per 2**exponent reference cycles
      if ((st.div_cnt & mask) == mask) begin // RULE_04
        next_st.tick    = 1'b1;
        next_st.div_cnt = '0;
      end else begin
        next_st.div_cnt = st.div_cnt + `RFCT_DIV_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

endmodule : rfct_prescaler

// [design/rfct_trigger.sv]
// qualifies sequencer events and software commands into start and stop pulses
`timescale 1ns/1ps
`include "rfct_defs.svh"

module rfct_trigger
  import rfct_pkg::*;
(
  input  logic         clk,
  input  logic         rst,
  input  rfct_events_t events,
  input  logic [7:0]   trig_cfg,
  input  logic         sw_start,
  input  logic         sw_stop,
  output logic         start,
  output logic         stop
);

  rfct_trig_state_t st;
  rfct_trig_state_t next_st;

  always_comb begin
    next_st.start = sw_start
                  | (trig_cfg[`RFCT_TRIG_LNCH_TXF] & events.tx_finish)     // RULE_07
                  | (trig_cfg[`RFCT_TRIG_LNCH_TX1] & events.tx_first_bit); // RULE_08
    next_st.stop  = sw_stop
                  | (trig_cfg[`RFCT_TRIG_HALT_RXF] & events.rx_finish)     // RULE_05
                  | (trig_cfg[`RFCT_TRIG_HALT_RX1] & events.rx_first_bit); // RULE_06
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign start = st.start;
  assign stop  = st.stop;

endmodule : rfct_trigger

// [design/rfct_timer.sv]
// countdown timer with AXI4-Lite register slave, prescaled tick and sequencer triggers
// Notes on behaviour
// RULE_01: auto-reload set: on expiry reload preset and keep counting.
// RULE_02: auto-reload clear: count to zero, stop, set expired flag.
// RULE_03: software programs divider exponent only from 0 to 21.
// RULE_04: tick rate is 13.56 MHz divided by two to the exponent.
// RULE_05: halt-at-receive-finish set: reception end stops the timer.
// RULE_06: halt-at-first-receive-bit set: first received bit stops the timer.
// RULE_07: launch-at-transmit-finish set: transmission end starts the timer.
// RULE_08: launch-at-first-transmit-bit set: first sent bit starts the timer.
// RULE_09: start while counting reloads the preset into the counter.
// RULE_10: software keeps unused upper bits of both config registers zero.
// RULE_11: start loads counter from preset; later preset changes wait for next start. With auto-reload set, expiry already reloads the current preset.
// RULE_12: zero preset: start events are ignored, timer stays stopped.
// RULE_13: decrement once per tick while running; hold count while stopped.
`timescale 1ns/1ps
`include "rfct_defs.svh"

module rfct_timer
  import rfct_pkg::*;
#(
  parameter int CLK_KHZ = `RFCT_CLK_KHZ,
  parameter int REF_KHZ = `RFCT_REF_KHZ
) (
  input  logic          clk,
  input  logic          rst,
  input  rfct_axi_req_t axi_req,
  output rfct_axi_rsp_t axi_rsp,
  input  rfct_events_t  seq_events,
  output logic          timer_running,
  output logic [7:0]    timer_count,
  output logic          countdown_expired_flag
);

  rfct_state_t st;
  rfct_state_t next_st;
  logic        start_pulse;
  logic        stop_pulse;
  logic        tick;

  // word index of a byte address
  function automatic logic [5:0] reg_index(input logic [`RFCT_ADDR_W-1:0] addr);
    reg_index = addr[`RFCT_ADDR_W-1:2];
  endfunction : reg_index

  // true for an index that holds a register
  function automatic logic is_mapped(input logic [5:0] idx);
    is_mapped = (idx == `RFCT_IDX_TICK_CFG) || (idx == `RFCT_IDX_TRIG_CFG) ||
                (idx == `RFCT_IDX_PRESET)   || (idx == `RFCT_IDX_CONTROL)  ||
                (idx == `RFCT_IDX_STATUS);
  endfunction : is_mapped

  rfct_trigger u_trigger (
    .clk      (clk),
    .rst      (rst),
    .events   (seq_events),
    .trig_cfg (st.timer_trigger_config),
    .sw_start (st.sw_start),
    .sw_stop  (st.sw_stop),
    .start    (start_pulse),
    .stop     (stop_pulse)
  );

  rfct_prescaler #(
    .CLK_KHZ (CLK_KHZ),
    .REF_KHZ (REF_KHZ)
  ) u_prescaler (
    .clk      (clk),
    .rst      (rst),
    .clear    (start_pulse),
    .exponent (st.timer_tick_config[`RFCT_TICK_EXP_MSB:0]),
    .tick     (tick)
  );

  always_comb begin
    logic [5:0]  widx;
    logic [5:0]  ridx;
    logic        do_write;
    logic        clr_expired;
    logic        set_expired;
    logic        auto_reload;
    logic [31:0] rd;
    next_st      = st;
    widx         = reg_index(st.aw_addr);
    ridx         = reg_index(axi_req.araddr);
    do_write     = st.aw_full && st.w_full && !st.rsp.bvalid;
    clr_expired  = 1'b0;
    set_expired  = 1'b0;
    auto_reload  = st.timer_tick_config[`RFCT_TICK_AUTO_BIT];
    rd           = 32'h0000_0000;
    next_st.sw_start = 1'b0;
    next_st.sw_stop  = 1'b0;

    // write address and data channels, taken in either order
    if (axi_req.awvalid && st.rsp.awready) begin
      next_st.aw_full = 1'b1;
      next_st.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st.rsp.wready) begin
      next_st.w_full = 1'b1;
      next_st.w_data = axi_req.wdata;
      next_st.w_strb = axi_req.wstrb;
    end

    // register write once both halves are held
    if (do_write) begin
      next_st.aw_full    = 1'b0;
      next_st.w_full     = 1'b0;
      next_st.rsp.bvalid = 1'b1;
      next_st.rsp.bresp  = is_mapped(widx) ? `RFCT_RESP_OKAY : `RFCT_RESP_SLVERR;
      if (st.w_strb[0]) begin
        case (widx)
          `RFCT_IDX_TICK_CFG: begin
            next_st.timer_tick_config = st.w_data[7:0] & `RFCT_TICK_WR_MASK;
          end
          `RFCT_IDX_TRIG_CFG: begin
            next_st.timer_trigger_config = st.w_data[7:0] & `RFCT_TRIG_WR_MASK;
          end
          `RFCT_IDX_PRESET: begin
            next_st.countdown_preset = st.w_data[7:0]; // RULE_11
          end
          `RFCT_IDX_CONTROL: begin
            next_st.sw_start = st.w_data[`RFCT_CTRL_START_BIT];
            next_st.sw_stop  = st.w_data[`RFCT_CTRL_STOP_BIT];
          end
          `RFCT_IDX_STATUS: begin
            clr_expired = st.w_data[`RFCT_STAT_EXP_BIT];
          end
          default: begin
          end
        endcase
      end
    end
    if (st.rsp.bvalid && axi_req.bready) begin
      next_st.rsp.bvalid = 1'b0;
    end
    next_st.rsp.awready = !next_st.aw_full;
    next_st.rsp.wready  = !next_st.w_full;

    // read channel
    case (ridx)
      `RFCT_IDX_TICK_CFG: begin
        rd[7:0] = st.timer_tick_config;
      end
      `RFCT_IDX_TRIG_CFG: begin
        rd[7:0] = st.timer_trigger_config;
      end
      `RFCT_IDX_PRESET: begin
        rd[7:0] = st.countdown_preset;
      end
      `RFCT_IDX_STATUS: begin
        rd[`RFCT_STAT_EXP_BIT] = st.countdown_expired_flag;
        rd[`RFCT_STAT_RUN_BIT] = (st.run == RFCT_COUNTING);
        rd[`RFCT_STAT_CNT_LSB +: 8] = st.count;
      end
      default: begin
      end
    endcase
    if (axi_req.arvalid && st.rsp.arready) begin
      next_st.rsp.rvalid = 1'b1;
      next_st.rsp.rdata  = rd;
      next_st.rsp.rresp  = is_mapped(ridx) ? `RFCT_RESP_OKAY : `RFCT_RESP_SLVERR;
    end else if (st.rsp.rvalid && axi_req.rready) begin
      next_st.rsp.rvalid = 1'b0;
    end
    next_st.rsp.arready = !next_st.rsp.rvalid;

    // timer: start wins over stop in the same cycle
    if (start_pulse) begin
      if (st.countdown_preset != 8'h00) begin // RULE_12
        next_st.count = st.countdown_preset; // RULE_09
        next_st.run   = RFCT_COUNTING; // RULE_11
      end
    end else if (stop_pulse) begin
      next_st.run = RFCT_IDLE; // RULE_05
    end else if (st.run == RFCT_COUNTING && tick) begin
      if (st.count > 8'h01) begin
        next_st.count = st.count - 8'h01; // RULE_13
      end else if (auto_reload && st.countdown_preset != 8'h00) begin
        next_st.count = st.countdown_preset; // RULE_01
      end else begin
        next_st.count = 8'h00; // RULE_02
        next_st.run   = RFCT_IDLE;
        set_expired   = 1'b1; // RULE_02
      end
    end

    // expired flag: a new expiry wins over a software clear
    if (set_expired) begin
      next_st.countdown_expired_flag = 1'b1;
    end else if (clr_expired) begin
      next_st.countdown_expired_flag = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st                      <= '0;
      st.run                  <= RFCT_IDLE;
      st.timer_tick_config    <= `RFCT_RST_TICK_CFG;
      st.timer_trigger_config <= `RFCT_RST_TRIG_CFG;
      st.countdown_preset     <= `RFCT_RST_PRESET;
    end else begin
      st <= next_st;
    end
  end

  assign axi_rsp                = st.rsp;
  assign timer_running          = (st.run == RFCT_COUNTING);
  assign timer_count            = st.count;
  assign countdown_expired_flag = st.countdown_expired_flag;

endmodule : rfct_timer

// [verification/rfct_seq_model.sv]
// sequencer model: one event pulse per request, after a chosen gap
`timescale 1ns/1ps
module rfct_seq_model
  import rfct_pkg::*;
(
  input  logic         clk,
  input  logic         rst,
  input  logic         go,
  input  logic [1:0]   sel,
  input  logic [3:0]   gap,
  output rfct_events_t ev
);
  logic [3:0] cnt;
  logic [1:0] s;
  logic       busy;
  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
      ev   <= '0;
    end else if (go) begin
      busy <= 1'b1;
      cnt  <= gap;
      s    <= sel;
      ev   <= '0;
    end else if (busy && cnt == 4'h0) begin
      busy <= 1'b0;
      ev   <= 4'h8 >> s;
    end else begin
      ev <= '0;
      if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule : rfct_seq_model

// [verification/rfct_timer_checker.sv]
// assertions on the countdown timer ports
`timescale 1ns/1ps
module rfct_timer_checker
  import rfct_pkg::*;
(
  input logic          clk,
  input logic          rst,
  input rfct_axi_req_t axi_req,
  input rfct_axi_rsp_t axi_rsp,
  input rfct_events_t  seq_events,
  input logic          timer_running,
  input logic [7:0]    timer_count,
  input logic          countdown_expired_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_hold_when_stopped:
    assert property (!timer_running && !$past(timer_running) |-> $stable(timer_count))
    else $error("count moved while stopped");
  a_fall_zero_flag:
    assert property ($fell(timer_running) && timer_count == 8'h00 |-> countdown_expired_flag)
    else $error("expiry without flag");
  a_run_nonzero:
    assert property (timer_running |-> timer_count != 8'h00)
    else $error("running at zero count");
  a_flag_at_zero:
    assert property ($rose(countdown_expired_flag) |-> !timer_running && timer_count == 8'h00)
    else $error("flag raised off zero");
  a_bresp_hold:
    assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped");
  a_rdata_hold:
    assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data dropped");
  a_read_answer:
    assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read answer late");
  a_write_answer:
    assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
      |-> ##[1:3] axi_rsp.bvalid)
    else $error("write answer late");
  a_ar_blocked:
    assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("address taken during read answer");
  cover property ($rose(countdown_expired_flag));
  cover property ($fell(timer_running) && timer_count != 8'h00);
  cover property (seq_events.rx_finish && timer_running);
  cover property (axi_rsp.bvalid && axi_rsp.bresp == 2'h2);
endmodule : rfct_timer_checker

bind rfct_timer rfct_timer_checker i_rfct_timer_checker (
  .clk(clk), .rst(rst), .axi_req(axi_req), .axi_rsp(axi_rsp), .seq_events(seq_events),
  .timer_running(timer_running), .timer_count(timer_count),
  .countdown_expired_flag(countdown_expired_flag));

// [verification/rfct_timer_tb.sv]
// self-checking bench of the countdown timer
`timescale 1ns/1ps
module rfct_timer_tb
  import rfct_pkg::*;
;
  typedef struct {logic [7:0] a; logic [31:0] w, e; logic [1:0] p;} rfct_row_t;
  rfct_row_t     rows [4] = '{'{8'hA8, 32'h20, 32'h20, 2'h0}, '{8'hAC, 32'h0F, 32'h0F, 2'h0},
                             '{8'hB0, 32'h05, 32'h05, 2'h0}, '{8'hFC, 32'h01, 32'h00, 2'h2}};
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  rfct_axi_req_t rq = '0;
  rfct_axi_rsp_t rs;
  rfct_events_t  ev;
  logic          tr, fl, go = 1'b0;
  logic [7:0]    tc, h;
  logic [1:0]    sel = 2'h0, r;
  logic [3:0]    gap = 4'h0;
  logic [31:0]   d;
  int            checks = 0, fails = 0, n;

  always #5 clk = ~clk;
  rfct_timer i_rfct_timer (.clk(clk), .rst(rst), .axi_req(rq), .axi_rsp(rs), .seq_events(ev),
    .timer_running(tr), .timer_count(tc), .countdown_expired_flag(fl));
  rfct_seq_model i_rfct_seq_model (.clk(clk), .rst(rst), .go(go), .sel(sel), .gap(gap), .ev(ev));

  task automatic finish_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic lim(input int k);
    if (k >= 300) begin
      fails++;
      finish_test();
    end
  endtask : lim
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    int k;
    rq.awaddr  <= a;
    rq.wdata   <= w;
    rq.awvalid <= 1'b1;
    rq.wvalid  <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
      if (rs.awready && rq.awvalid) rq.awvalid <= 1'b0;
      if (rs.wready && rq.wvalid) rq.wvalid <= 1'b0;
    end while (rs.bvalid !== 1'b1 && k < 300);
    r = rs.bresp;
    lim(k);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int k;
    rq.araddr  <= a;
    rq.arvalid <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
      if (rs.arready && rq.arvalid) rq.arvalid <= 1'b0;
    end while (rs.rvalid !== 1'b1 && k < 300);
    d = rs.rdata;
    r = rs.rresp;
    lim(k);
  endtask : rd
  task automatic wt(input logic v);
    n = 0;
    while (tr !== v && n < 300) begin
      @(posedge clk);
      n++;
    end
    lim(n);
  endtask : wt
  task automatic fire(input logic [1:0] s, input logic [3:0] g);
    go  <= 1'b1;
    sel <= s;
    gap <= g;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
  endtask : fire

  initial begin
    rq.wstrb  = 4'hF;
    rq.bready = 1'b1;
    rq.rready = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      chk("bresp", rows[i].p, r);
      rd(rows[i].a);
      chk("rdata", rows[i].e, d);
      chk("rresp", rows[i].p, r);
    end
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'hA8);
    chk("tick_rst", 32'h0B, d);
    rd(8'hAC);
    chk("trig_rst", 32'h02, d);
    rd(8'hB0);
    chk("preset_rst", 32'h00, d);
    wr(8'hA8, 32'h02);
    wr(8'hB0, 32'h03);
    wr(8'hAC, 32'h01);
    fire(2'h0, 4'h0);
    wt(1'b1);
    chk("load", 8'h03, tc);
    wt(1'b0);
    chk("span", 1, n >= 83 && n <= 93);
    chk("end_count", 8'h00, tc);
    chk("flag", 1'b1, fl);
    wr(8'hC4, 32'h01);
    rd(8'hC4);
    chk("flag_clr", 1'b0, d[0]);
    wr(8'hAC, 32'h00);
    fire(2'h0, 4'h3);
    repeat (10) @(posedge clk);
    chk("tx1_off", 1'b0, tr);
    wr(8'hAC, 32'h01);
    wr(8'hB0, 32'h00);
    fire(2'h0, 4'h0);
    repeat (8) @(posedge clk);
    chk("zero_preset", 1'b0, tr);
    wr(8'hB0, 32'h40);
    wr(8'hA8, 32'h00);
    wr(8'hAC, 32'h02);
    fire(2'h1, 4'h5);
    wt(1'b1);
    fire(2'h3, 4'h0);
    fire(2'h2, 4'h0);
    repeat (30) @(posedge clk);
    chk("rx_off", 1'b1, tr);
    wr(8'hB0, 32'h10);
    chk("late_preset", 1, tc > 8'h10 && tc < 8'h40);
    fire(2'h1, 4'h0);
    repeat (3) @(posedge clk);
    chk("restart", 1, tc >= 8'h0F && tc <= 8'h10);
    wr(8'hAC, 32'h06);
    fire(2'h2, 4'h0);
    wt(1'b0);
    h = tc;
    repeat (30) @(posedge clk);
    chk("held", h, tc);
    wr(8'hAC, 32'h0A);
    fire(2'h1, 4'h0);
    wt(1'b1);
    fire(2'h3, 4'h0);
    wt(1'b0);
    chk("no_flag", 1'b0, fl);
    wr(8'hA8, 32'h20);
    wr(8'hB0, 32'h02);
    fire(2'h1, 4'h0);
    wt(1'b1);
    repeat (100) @(posedge clk);
    chk("auto_run", 1'b1, tr);
    chk("auto_flag", 1'b0, fl);
    wr(8'hC0, 32'h02);
    wt(1'b0);
    finish_test();
  end
endmodule : rfct_timer_tb
